// [bench/eeprom_array_model.sv]
`default_nettype none
// Expected array contents; the bench records each write it commands
module eeprom_array_model
    import eeprom_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [DEPTH];  // Bytes as the array should hold them
    // A stored byte stays until overwritten, so reads can be predicted
    task automatic store(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        mem[a] = d;
    endtask
endmodule
`default_nettype wire

// [bench/eeprom_data_control_regs_tb.sv]
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("FAIL %0t got %h want %h", $time, g, e); end end
module eeprom_data_control_regs_tb
    import eeprom_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WCYC = 20;  // Short write time keeps the run brief
    logic        clk, sys_rst, psel, penable, pwrite;  // Clock, reset, bus strobes
    logic [7:0]  paddr;                                // Byte address
    logic [31:0] pwdata, prdata, rd;                   // Bus data and last read
    logic        pready, pslverr, irq;                 // Block outputs
    logic        err;                                  // Last error response
    int          n_mismatch, total_checks;             // Verdict counters
    eeprom_data_control_regs #(.WRITE_CYCLES_P(WCYC)) DUT (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    eeprom_array_model arr_model ();
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // One transfer; ready, read data and error are looked at mid-cycle, where they
    // already stand as the next rising edge sees them, and kept from the last one
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int   i;
        logic done;
        i = 0;
        done = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        while (!done && i < 50) begin
            @(negedge clk);
            done = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
            @(posedge clk);
            i++;
        end
        if (!done) begin
            n_mismatch++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll the control register until a trigger bit drops; a hang ends the run
    task automatic wait_clear(input int b);
        int i;
        i = 0;
        do begin
            apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);
            i++;
        end while (rd[b] !== 1'b0 && i < 100);
        if (rd[b] !== 1'b0) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic t_reset();
        apb(1'b0, ADDR_BYTE_DATA, 32'h0);    `CHK(rd, 32'h0)
        apb(1'b0, ADDR_BYTE_ADDRESS, 32'h0); `CHK(rd, 32'h0)
        apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);   `CHK(rd, 32'h0)
        `CHK(irq, 1'b0)
    endtask
    // All ones written to data and address, upper bits only to control; only implemented bits come back, unmapped reads zero
    task automatic t_fields();
        apb(1'b1, ADDR_BYTE_DATA, 32'hFFFFFFFF);
        apb(1'b0, ADDR_BYTE_DATA, 32'h0);      `CHK(rd, 32'hFF)
        apb(1'b1, ADDR_BYTE_ADDRESS, 32'hFFFFFFFF);
        apb(1'b0, ADDR_BYTE_ADDRESS, 32'h0);   `CHK(rd, 32'h3F)
        apb(1'b1, ADDR_CYCLE_CTRL, 32'hF0);
        apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);     `CHK(rd, 32'h0)
        apb(1'b0, 8'h14, 32'h0);               `CHK(rd, 32'h0)
        `CHK(err, 1'b1)
        apb(1'b0, ADDR_IRQ_MASK, 32'h0);       `CHK(err, 1'b0)
    endtask
    // Triggers without a stored permit, including permit in the same write
    task automatic t_refuse();
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h4);
        apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);     `CHK(rd, 32'h0)
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h1);
        apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);     `CHK(rd, 32'h0)
        apb(1'b1, ADDR_CYCLE_CTRL, 32'hC);
        apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);     `CHK(rd, 32'h8)
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);     `CHK(rd, 32'h0)
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h0);
    endtask
    task automatic t_write();
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, ADDR_BYTE_ADDRESS, 32'h5);
        apb(1'b1, ADDR_BYTE_DATA, 32'hA5);
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h8);
        apb(1'b1, ADDR_CYCLE_CTRL, 32'hC);
        arr_model.store(6'h05, 8'hA5);
        apb(1'b0, ADDR_CYCLE_CTRL, 32'h0);     `CHK(rd[2], 1'b1)
        wait_clear(2);                         `CHK(rd, 32'h8)
        `CHK(irq, 1'b1)
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);     `CHK(rd, 32'h1)
        `CHK(irq, 1'b0)
    endtask
    // Data register overwritten first, so the fetched byte must replace it
    task automatic t_read();
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h0);
        apb(1'b1, ADDR_BYTE_DATA, 32'h5A);
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h2);
        apb(1'b1, ADDR_CYCLE_CTRL, 32'h3);
        wait_clear(0);                         `CHK(rd, 32'h2)
        apb(1'b0, ADDR_BYTE_DATA, 32'h0);      `CHK(rd, {24'h0, arr_model.mem[5]})
        `CHK(irq, 1'b0)
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0);     `CHK(rd, 32'h2)
    endtask
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, rd, err} = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_fields();
        t_refuse();
        t_write();
        t_read();
        summarize();
    end
endmodule
`default_nettype wire

// [bench/eeprom_regs_chk.sv]
`default_nettype none
// Bus-side checks on the register block ports
module eeprom_regs_chk
    import eeprom_regs_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES  // Write time, kept in step with the block
)
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic acc;     // Access phase of a transfer
    logic rd;      // Access phase of a read
    logic mapped;  // Address hits a register
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    assign mapped = paddr inside {ADDR_BYTE_DATA, ADDR_BYTE_ADDRESS, ADDR_CYCLE_CTRL,
                                  ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_ready; acc |-> (pready or (!pwrite ##1 pready)); endproperty
    a_ready: assert property (p_ready) else $error("access not completed in time");
    property p_ok; acc && mapped |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("error on mapped address");
    property p_err; acc && !mapped |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error on unmapped address");
    property p_err_zero; rd && !mapped |=> prdata == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
    property p_data_w; rd && paddr == ADDR_BYTE_DATA |=> prdata[31:8] == 24'h0; endproperty
    a_data_w: assert property (p_data_w) else $error("data read too wide");
    property p_addr_w; rd && paddr == ADDR_BYTE_ADDRESS |=> prdata[31:6] == 26'h0; endproperty
    a_addr_w: assert property (p_addr_w) else $error("address read too wide");
    property p_ctrl_w; rd && paddr == ADDR_CYCLE_CTRL |=> prdata[31:4] == 28'h0; endproperty
    a_ctrl_w: assert property (p_ctrl_w) else $error("control upper bits set");
    property p_hold; !rd |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_irq_rst; $fell(sys_rst) |-> !irq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("interrupt after reset");
    // Main scenarios reached
    c_trig: cover property (acc && pwrite && paddr == ADDR_CYCLE_CTRL && pwdata[BIT_WRITE_TRIG]);
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (acc && !mapped);
endmodule
bind eeprom_data_control_regs eeprom_regs_chk #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
`default_nettype wire

// [src/eeprom_byte_array.sv]
`default_nettype none
// Storage array: one-cycle write, registered read port
module eeprom_byte_array
    import eeprom_regs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic      [DATA_W-1:0] rd_data
);
    // Contents survive reset, as non-volatile storage should
    logic [DATA_W-1:0] mem [DEPTH];

    // Write and read share one address
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule
`default_nettype wire

// [src/eeprom_data_control_regs.sv]
// Decided for this implementation: the address map and the APB interface to the registers.
`default_nettype none
// Behaviour
// - 8-bit data register, resets to zero
// - Control upper four bits read zero
// - Write permit bit gates write cycles
// - Write trigger starts write, reads busy
// - Write trigger self-clears at cycle end
// - Write trigger ignored without prior permit
// - Read permit bit gates read cycles
// - Read trigger starts read, self-clears
// - Read trigger ignored without prior permit
// - 6-bit address register, upper bits zero
// - Read result held in data register
// - Write completion sets done flag
module eeprom_data_control_regs
    import eeprom_regs_pkg::*;
#(
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    // Register map, one aligned word each, fields in the low bits:
    //   data     - byte moved to or from the array
    //   address  - byte selected in the array, upper bits read zero
    //   control  - write permit, write trigger, read permit, read trigger
    //   status   - read done, write done; a read clears both
    //   mask     - same layout as status, gates the interrupt
    // A cycle in flight freezes the address, and the data register too during
    // a write, so software cannot change what the array sees mid-cycle

    // Register state
    logic [DATA_W-1:0] data_q, data_d;          // Byte data register
    logic [ADDR_W-1:0] addr_q, addr_d;          // Byte address register
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;          // Permit and trigger bits
    logic [IRQ_W-1:0]  stat_q, stat_d;          // Sticky event flags
    logic [IRQ_W-1:0]  mask_q, mask_d;          // Interrupt enables
    logic [31:0]       rdata_q, rdata_d;        // Registered read data
    cycle_state_e      state_q, state_d;        // Cycle sequencer
    logic [CNT_W-1:0]  cnt_q, cnt_d;            // Cycle timer

    // Bus strobes
    logic              access;                  // Access phase
    logic              wr_acc;                  // Register write
    logic              rd_acc;                  // Register read
    logic              mapped;                  // Address decodes
    logic              arr_we;                  // Array write strobe
    logic [DATA_W-1:0] arr_rd;                  // Array read data
    logic              write_end;               // Write cycle finishes
    logic              read_end;                // Read cycle finishes
    logic              start_wr;                // Accepted write trigger
    logic              start_rd;                // Accepted read trigger
    logic              rd_first;                // First access cycle of a read
    logic              rd_valid_q, rd_valid_d;  // Read word staged in rdata_q
    logic              sel_data;                // Data register addressed
    logic              sel_addr;                // Address register addressed
    logic              sel_ctrl;                // Control register addressed
    logic              sel_stat;                // Status register addressed
    logic              sel_mask;                // Mask register addressed

    // Zero-extends a narrow field into a bus word
    function automatic logic [31:0] widen(input logic [DATA_W-1:0] v);
        widen = {24'h000000, v};
    endfunction

    // True on the last counted clock of a timed cycle
    function automatic logic last_tick(input logic [CNT_W-1:0] c);
        last_tick = (c == CNT_W'(1));
    endfunction

    // Compares the bus address with one register's byte address
    function automatic logic hits(input logic [7:0] a, input logic [7:0] reg_addr);
        hits = (a == reg_addr);
    endfunction

    // Writes finish in their first access cycle; a read inserts one wait
    // state so the word it returns comes straight from a flip-flop, at the
    // price of one extra bus cycle per read
    assign pready  = ~rd_acc | rd_valid_q;
    assign access  = psel & penable;
    assign wr_acc  = access & pwrite;
    assign rd_acc  = access & ~pwrite;
    assign rd_first = rd_acc & ~rd_valid_q;
    // One decoded select per register
    assign sel_data = hits(paddr, ADDR_BYTE_DATA);
    assign sel_addr = hits(paddr, ADDR_BYTE_ADDRESS);
    assign sel_ctrl = hits(paddr, ADDR_CYCLE_CTRL);
    assign sel_stat = hits(paddr, ADDR_IRQ_STATUS);
    assign sel_mask = hits(paddr, ADDR_IRQ_MASK);
    assign mapped  = sel_data | sel_addr | sel_ctrl | sel_stat | sel_mask;
    // Unmapped addresses answer with an error and change nothing
    assign pslverr = access & ~mapped;
    assign prdata  = rdata_q;
    assign irq     = |(stat_q & mask_q);

    // Trigger acceptance uses the permit already stored, never the one
    // arriving in the same write, so permit must be set beforehand
    assign start_wr = wr_acc && sel_ctrl && (state_q == ST_IDLE) &&
                      pwdata[BIT_WRITE_TRIG] && ctrl_q[BIT_WRITE_PERMIT];
    assign start_rd = wr_acc && sel_ctrl && (state_q == ST_IDLE) &&
                      pwdata[BIT_READ_TRIG] && ctrl_q[BIT_READ_PERMIT] &&
                      !start_wr;
    // Cycle ends flag the last counted clock, so the array write, the fetched
    // byte and the return to idle all land on one edge
    assign write_end = (state_q == ST_WRITE) && last_tick(cnt_q);
    assign read_end  = (state_q == ST_READ) && last_tick(cnt_q);
    assign arr_we    = write_end;

    // Storage array, written at the close of a write cycle
    // Its read port runs every cycle; only the byte seen at read_end is used
    eeprom_byte_array u_array (
        .clk     (clk),
        .wr_en   (arr_we),
        .addr    (addr_q),
        .wr_data (data_q),
        .rd_data (arr_rd)
    );

    // Cycle sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                // Write is tested first: should both triggers arrive together,
                // only the write runs
                if (start_wr) begin
                    state_d = ST_WRITE;
                    cnt_d   = CNT_W'(WRITE_CYCLES_P);
                end else if (start_rd) begin
                    state_d = ST_READ;
                    cnt_d   = CNT_W'(READ_CYCLES);
                end
            end
            ST_READ, ST_WRITE: begin
                // Count down; the last tick returns to idle
                cnt_d = cnt_q - CNT_W'(1);
                if (last_tick(cnt_q)) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                // Unused encoding, recover to idle
                state_d = ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Data and address next values; the data register takes software writes
    // and, at the close of a read cycle, the fetched byte
    always_comb begin
        data_d = data_q;
        addr_d = addr_q;
        if (wr_acc && sel_data && (state_q != ST_WRITE)) begin
            // Held steady while a write cycle copies it into the array
            data_d = pwdata[DATA_W-1:0];
        end
        if (wr_acc && sel_addr && (state_q == ST_IDLE)) begin
            // Frozen while busy so a running cycle keeps its byte
            addr_d = pwdata[ADDR_W-1:0];
        end
        if (read_end) begin
            // Fetched byte replaces whatever software left there
            data_d = arr_rd;
        end
    end

    // Data and address registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_q <= DATA_RST;
            addr_q <= ADDR_RST;
        end else begin
            data_q <= data_d;
            addr_q <= addr_d;
        end
    end

    // Control next value; permits store freely, triggers only when accepted,
    // and the hardware drops a trigger at the end of its own cycle
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_acc && sel_ctrl) begin
            ctrl_d[BIT_WRITE_PERMIT] = pwdata[BIT_WRITE_PERMIT];
            ctrl_d[BIT_READ_PERMIT]  = pwdata[BIT_READ_PERMIT];
        end
        if (start_wr) begin
            ctrl_d[BIT_WRITE_TRIG] = 1'b1;
        end
        if (start_rd) begin
            ctrl_d[BIT_READ_TRIG] = 1'b1;
        end
        if (write_end) begin
            ctrl_d[BIT_WRITE_TRIG] = 1'b0;
        end
        if (read_end) begin
            ctrl_d[BIT_READ_TRIG] = 1'b0;
        end
        // Losing permit mid-cycle does not abort a running cycle
    end

    // Control register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Status and mask next values; a status read clears the flags, and an
    // event in that same cycle is applied last so it is never lost
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (wr_acc && sel_mask) begin
            mask_d = pwdata[IRQ_W-1:0];
        end
        if (rd_first && sel_stat) begin
            // Cleared as the word is captured, so the flags returned go
            stat_d = '0;
        end
        if (write_end) begin
            stat_d[BIT_WRITE_DONE] = 1'b1;
        end
        if (read_end) begin
            stat_d[BIT_READ_DONE] = 1'b1;
        end
    end

    // Status and mask registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= IRQ_RST;
            mask_q <= IRQ_RST;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // Read word next value, captured in the first access cycle of a read;
    // unmapped addresses return zero
    always_comb begin
        rdata_d = rdata_q;
        if (rd_first) begin
            unique case (paddr)
                ADDR_BYTE_DATA:    rdata_d = widen(data_q);
                ADDR_BYTE_ADDRESS: rdata_d = widen({2'b00, addr_q});
                ADDR_CYCLE_CTRL:   rdata_d = widen({4'h0, ctrl_q});
                ADDR_IRQ_STATUS:   rdata_d = widen({6'h00, stat_q});
                ADDR_IRQ_MASK:     rdata_d = widen({6'h00, mask_q});
                default:           rdata_d = '0;
            endcase
        end
    end

    // Read word register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Read staging next value: set by the first access cycle of a read and
    // dropped by the completing one, so the next read waits again
    always_comb begin
        rd_valid_d = rd_first;
    end

    // Read staging register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_valid_d;
        end
    end
endmodule
`default_nettype wire

// [src/eeprom_regs_pkg.sv]
`default_nettype none
package eeprom_regs_pkg;
    // Register byte addresses on the APB bus
    localparam logic [7:0] ADDR_BYTE_DATA    = 8'h00;
    localparam logic [7:0] ADDR_BYTE_ADDRESS = 8'h04;
    localparam logic [7:0] ADDR_CYCLE_CTRL   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK     = 8'h10;
    // Control register field positions
    localparam int BIT_READ_TRIG    = 0;
    localparam int BIT_READ_PERMIT  = 1;
    localparam int BIT_WRITE_TRIG   = 2;
    localparam int BIT_WRITE_PERMIT = 3;
    // Status and mask field positions
    localparam int BIT_WRITE_DONE   = 0;
    localparam int BIT_READ_DONE    = 1;
    // Widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int CTRL_W = 4;
    localparam int IRQ_W  = 2;
    localparam int DEPTH  = 64;
    // Reset values
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;
    // Cycle timing at 100 MHz
    localparam int CLK_PERIOD_NS  = 10;
    localparam int READ_TIME_NS   = 40;
    localparam int WRITE_TIME_NS  = 2000;
    localparam int READ_CYCLES    = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYCLES   = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 12;
    // Cycle sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} cycle_state_e;
endpackage
`default_nettype wire
